// ---- hw/self_check_seq.sv ----
// power-on self-check sequencer: test sequence, pass/fail led codes
// Contract
// - enter on reset release with both straps
// - runs from self-check region 3f00..3fef
// - functional test of ports A, B, C
// - counting test of every RAM byte
// - timer counter advance and compare flag
// - async serial flags checked in transmission
// - ROM xor of all bytes, odd parity
// - sync serial done and collision flags
// - failure led codes per test
// - flash leds on pass; others mean device failure
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
module self_check_seq
   import selfcheck_pkg::*;
#(
   parameter int unsigned FLASH_HALF_CYC = selfcheck_pkg::FLASH_HALF_CYC_DEF
) (
   input  wire logic                            clk,                  // core clock
   input  wire logic                            rst,                  // async reset, high
   input  wire logic                            irqTestLevel,         // irq pin at test level
   input  wire logic                            captureInputPin,      // capture pin level
   input  wire logic [7:0]                      portAIn,              // port A pin levels
   input  wire logic [7:0]                      portBIn,              // port B pin levels
   input  wire logic [7:0]                      portCIn,              // port C pin levels
   output logic      [7:0]                      portAOut,             // port A drive value
   output logic      [7:0]                      portBOut,             // port B drive value
   output logic      [7:0]                      portCOut,             // port C drive value
   output logic                                 portOe,               // ports driven
   output logic      [selfcheck_pkg::RAM_AW-1:0] ramAddr,             // RAM address
   output logic      [7:0]                      ramWdata,             // RAM write data
   output logic                                 ramWe,                // RAM write strobe
   output logic                                 ramRe,                // RAM read strobe
   input  wire logic [7:0]                      ramRdata,             // RAM data, cycle after
   output logic      [selfcheck_pkg::ROM_AW-1:0] romAddr,             // ROM address
   output logic                                 romRe,                // ROM read strobe
   input  wire logic [7:0]                      romRdata,             // ROM data, cycle after
   input  wire logic [15:0]                     timerCount,           // free-running counter
   input  wire logic                            outputCompareFlag,    // timer compare flag
   output logic                                 compareArm,           // arm timer compare
   output logic                                 sciGo,                // start async transmit
   output logic      [7:0]                      sciTxData,            // async transmit byte
   input  wire logic [7:0]                      sciRxData,            // async received byte
   input  wire logic                            receiveFullFlag,      // async receive full
   input  wire logic                            transmitEmptyFlag,    // async tx data empty
   input  wire logic                            transmitCompleteFlag, // async tx complete
   input  wire logic                            framingErrorFlag,     // async framing error
   output logic                                 spiGo,                // start sync transfer
   input  wire logic                            syncTransferDoneFlag, // sync transfer done
   input  wire logic                            writeCollisionFlag,   // sync write collision
   output logic                                 selfCheckActive,      // self-check mode on
   output logic                                 selfCheckDone,        // result shown
   output logic      [15:0]                     checkPc,              // self-check fetch addr
   output logic                                 statusLed3,           // led 3, high is on
   output logic                                 statusLed2,           // led 2, high is on
   output logic                                 statusLed1,           // led 1, high is on
   output logic                                 statusLed0            // led 0, high is on
);

   typedef struct packed {
      state_t              st;
      logic [1:0]          sub;
      logic                pass;
      logic [CNT_W-1:0]    cnt;
      logic [FLASH_W-1:0]  flashCnt;
      logic                flash;
      logic [ROM_AW-1:0]   addr;
      logic [7:0]          acc;
      logic [15:0]         prev;
      logic [2:0]          seen;
      logic [3:0]          led;
      logic                active;
      logic                done;
      logic [15:0]         pc;
      logic [7:0]          portA;
      logic [7:0]          portB;
      logic [7:0]          portC;
      logic                oe;
      logic [RAM_AW-1:0]   ramAddr;
      logic [7:0]          ramWdata;
      logic                ramWe;
      logic                ramRe;
      logic                romRe;
      logic                compareArm;
      logic                sciGo;
      logic                spiGo;
      logic [7:0]          sciTx;
   } ctl_t;

   localparam ctl_t CTL_RESET = '{st: ST_IDLE, default: '0};

   ctl_t        ctl_q;
   ctl_t        ctl_d;
   logic [25:0] pinSync;
   logic        irqS;
   logic        capS;
   logic [7:0]  portAS;
   logic [7:0]  portBS;
   logic [7:0]  portCS;

   // every pin level here is asynchronous to the core clock
   sync_2ff #(
      .W (26)
   ) u_pin_sync (
      .clk (clk),
      .rst (rst),
      .d   ({irqTestLevel, captureInputPin, portAIn, portBIn, portCIn}),
      .q   (pinSync)
   );

   assign irqS   = pinSync[25];
   assign capS   = pinSync[24];
   assign portAS = pinSync[23:16];
   assign portBS = pinSync[15:8];
   assign portCS = pinSync[7:0];

   always_comb
   begin
      logic       fail;
      logic [3:0] code;
      logic [7:0] pat;
      logic [7:0] accNext;
      logic [2:0] seenNext;
      fail     = 1'b0;
      code     = LED_OFF;
      pat      = ctl_q.sub[0] ? PORT_PAT1 : PORT_PAT0;
      accNext  = ctl_q.acc ^ romRdata;
      seenNext = ctl_q.seen;
      ctl_d    = ctl_q;
      // strobes are single-cycle unless a state raises them again
      ctl_d.ramWe      = 1'b0;
      ctl_d.ramRe      = 1'b0;
      ctl_d.romRe      = 1'b0;
      ctl_d.compareArm = 1'b0;
      ctl_d.sciGo      = 1'b0;
      ctl_d.spiGo      = 1'b0;
      if (ctl_q.active && !ctl_q.done)
      begin
         // fetch walks the self-check region and wraps inside it
         ctl_d.pc = (ctl_q.pc == SELF_ROM_LAST) ? SELF_ROM_FIRST : ctl_q.pc + PC_STEP;
      end
      unique case (ctl_q.st)
         ST_IDLE:
         begin
            // straps are read once the synchroniser holds post-release levels
            if (ctl_q.cnt == CNT_W'(SYNC_DEPTH))
            begin
               ctl_d.cnt = '0;
               if (irqS && capS)
               begin
                  ctl_d.st     = ST_PORT;
                  ctl_d.active = 1'b1;
                  ctl_d.pc     = SELF_ROM_FIRST;
                  ctl_d.sub    = '0;
               end
               else
               begin
                  ctl_d.st = ST_OFF;
               end
            end
            else
            begin
               ctl_d.cnt = ctl_q.cnt + 1'b1;
            end
         end
         ST_OFF:
         begin
            ctl_d.led = LED_OFF;
         end
         ST_PORT:
         begin
            // drive a pattern and read it back through the pins
            ctl_d.oe    = 1'b1;
            ctl_d.portA = pat;
            ctl_d.portB = pat;
            ctl_d.portC = pat;
            if (ctl_q.cnt == CNT_W'(PORT_SETTLE))
            begin
               ctl_d.cnt = '0;
               if (portAS != pat || portBS != pat || portCS != pat)
               begin
                  fail = 1'b1;
                  code = LED_IO;
               end
               else if (ctl_q.sub[0])
               begin
                  ctl_d.oe   = 1'b0;
                  ctl_d.st   = ST_RAMW;
                  ctl_d.addr = '0;
                  ctl_d.pass = 1'b0;
               end
               else
               begin
                  ctl_d.sub = 2'b01;
               end
            end
            else
            begin
               ctl_d.cnt = ctl_q.cnt + 1'b1;
            end
         end
         ST_RAMW:
         begin
            // every byte gets the low 8 bits of its address, inverted on the second pass
            ctl_d.ramWe    = 1'b1;
            ctl_d.ramAddr  = ctl_q.addr[RAM_AW-1:0];
            ctl_d.ramWdata = ctl_q.addr[7:0] ^ {8{ctl_q.pass}};
            if (ctl_q.addr == RAM_LAST)
            begin
               ctl_d.addr = '0;
               ctl_d.sub  = '0;
               ctl_d.st   = ST_RAMR;
            end
            else
            begin
               ctl_d.addr = ctl_q.addr + ADDR_ONE;
            end
         end
         ST_RAMR:
         begin
            unique case (ctl_q.sub)
               2'b00:
               begin
                  ctl_d.ramRe   = 1'b1;
                  ctl_d.ramAddr = ctl_q.addr[RAM_AW-1:0];
                  ctl_d.sub     = 2'b01;
               end
               2'b01:
               begin
                  ctl_d.sub = 2'b10;
               end
               default:
               begin
                  ctl_d.sub = 2'b00;
                  if (ramRdata != (ctl_q.addr[7:0] ^ {8{ctl_q.pass}}))
                  begin
                     fail = 1'b1;
                     code = LED_RAM;
                  end
                  else if (ctl_q.addr != RAM_LAST)
                  begin
                     ctl_d.addr = ctl_q.addr + ADDR_ONE;
                  end
                  else if (!ctl_q.pass)
                  begin
                     ctl_d.pass = 1'b1;
                     ctl_d.addr = '0;
                     ctl_d.st   = ST_RAMW;
                  end
                  else
                  begin
                     ctl_d.st = ST_TIMER;
                  end
               end
            endcase
         end
         ST_TIMER:
         begin
            unique case (ctl_q.sub)
               2'b00:
               begin
                  ctl_d.prev       = timerCount;
                  ctl_d.compareArm = 1'b1;
                  ctl_d.cnt        = '0;
                  ctl_d.sub        = 2'b01;
               end
               2'b01:
               begin
                  // the counter must have moved after a short gap
                  if (ctl_q.cnt == CNT_W'(TIMER_GAP))
                  begin
                     ctl_d.cnt = '0;
                     if (timerCount == ctl_q.prev)
                     begin
                        fail = 1'b1;
                        code = LED_TIMER;
                     end
                     else
                     begin
                        ctl_d.sub = 2'b10;
                     end
                  end
                  else
                  begin
                     ctl_d.cnt = ctl_q.cnt + 1'b1;
                  end
               end
               default:
               begin
                  if (outputCompareFlag)
                  begin
                     ctl_d.st  = ST_SCI;
                     ctl_d.sub = '0;
                  end
                  else if (ctl_q.cnt == CNT_W'(TIMEOUT_CYC))
                  begin
                     fail = 1'b1;
                     code = LED_TIMER;
                  end
                  else
                  begin
                     ctl_d.cnt = ctl_q.cnt + 1'b1;
                  end
               end
            endcase
         end
         ST_SCI:
         begin
            if (ctl_q.sub == 2'b00)
            begin
               ctl_d.sciGo = 1'b1;
               ctl_d.sciTx = SCI_PATTERN;
               ctl_d.cnt   = '0;
               ctl_d.seen  = '0;
               ctl_d.sub   = 2'b01;
            end
            else
            begin
               // flags are sticky here so their order of arrival does not matter
               seenNext   = ctl_q.seen | {receiveFullFlag, transmitEmptyFlag,
                                          transmitCompleteFlag};
               ctl_d.seen = seenNext;
               if (framingErrorFlag || (receiveFullFlag && sciRxData != SCI_PATTERN))
               begin
                  fail = 1'b1;
                  code = LED_SCI;
               end
               else if (&seenNext)
               begin
                  ctl_d.st   = ST_ROM;
                  ctl_d.sub  = '0;
                  ctl_d.addr = '0;
                  ctl_d.acc  = '0;
               end
               else if (ctl_q.cnt == CNT_W'(TIMEOUT_CYC))
               begin
                  fail = 1'b1;
                  code = LED_SCI;
               end
               else
               begin
                  ctl_d.cnt = ctl_q.cnt + 1'b1;
               end
            end
         end
         ST_ROM:
         begin
            unique case (ctl_q.sub)
               2'b00:
               begin
                  ctl_d.romRe = 1'b1;
                  ctl_d.sub   = 2'b01;
               end
               2'b01:
               begin
                  ctl_d.sub = 2'b10;
               end
               default:
               begin
                  // all bytes fold into one, which must hold an odd count of ones
                  ctl_d.acc = accNext;
                  ctl_d.sub = 2'b00;
                  if (ctl_q.addr != ROM_LAST)
                  begin
                     ctl_d.addr = ctl_q.addr + ADDR_ONE;
                  end
                  else if (^accNext)
                  begin
                     ctl_d.st  = ST_SPI;
                     ctl_d.cnt = '0;
                  end
                  else
                  begin
                     fail = 1'b1;
                     code = LED_ROM;
                  end
               end
            endcase
         end
         ST_SPI:
         begin
            unique case (ctl_q.sub)
               2'b00:
               begin
                  ctl_d.spiGo = 1'b1;
                  ctl_d.sub   = 2'b01;
               end
               2'b01:
               begin
                  // second write lands mid-transfer on purpose to raise a collision
                  ctl_d.spiGo = 1'b1;
                  ctl_d.cnt   = '0;
                  ctl_d.seen  = '0;
                  ctl_d.sub   = 2'b10;
               end
               default:
               begin
                  seenNext   = ctl_q.seen | {1'b0, syncTransferDoneFlag, writeCollisionFlag};
                  ctl_d.seen = seenNext;
                  if (&seenNext[1:0])
                  begin
                     ctl_d.st   = ST_PASS;
                     ctl_d.done = 1'b1;
                  end
                  else if (ctl_q.cnt == CNT_W'(TIMEOUT_CYC))
                  begin
                     fail = 1'b1;
                     code = LED_SPI;
                  end
                  else
                  begin
                     ctl_d.cnt = ctl_q.cnt + 1'b1;
                  end
               end
            endcase
         end
         ST_PASS:
         begin
            // all leds blink together, a pattern no failure code uses
            if (ctl_q.flashCnt == FLASH_W'(FLASH_HALF_CYC - 1))
            begin
               ctl_d.flashCnt = '0;
               ctl_d.flash    = ~ctl_q.flash;
            end
            else
            begin
               ctl_d.flashCnt = ctl_q.flashCnt + 1'b1;
            end
            ctl_d.led = ctl_d.flash ? LED_ALL_ON : LED_OFF;
         end
         ST_FAIL:
         begin
            ctl_d.led = ctl_q.led;
         end
         default:
         begin
            ctl_d.st = ST_OFF;
         end
      endcase
      // the first failure freezes the sequence with its code
      if (fail)
      begin
         ctl_d.st   = ST_FAIL;
         ctl_d.led  = code;
         ctl_d.done = 1'b1;
         ctl_d.oe   = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctl_q <= CTL_RESET;
      end
      else
      begin
         ctl_q <= ctl_d;
      end
   end

   assign portAOut        = ctl_q.portA;
   assign portBOut        = ctl_q.portB;
   assign portCOut        = ctl_q.portC;
   assign portOe          = ctl_q.oe;
   assign ramAddr         = ctl_q.ramAddr;
   assign ramWdata        = ctl_q.ramWdata;
   assign ramWe           = ctl_q.ramWe;
   assign ramRe           = ctl_q.ramRe;
   assign romAddr         = ctl_q.addr;
   assign romRe           = ctl_q.romRe;
   assign compareArm      = ctl_q.compareArm;
   assign sciGo           = ctl_q.sciGo;
   assign sciTxData       = ctl_q.sciTx;
   assign spiGo           = ctl_q.spiGo;
   assign selfCheckActive = ctl_q.active;
   assign selfCheckDone   = ctl_q.done;
   assign checkPc         = ctl_q.pc;
   assign statusLed3      = ctl_q.led[3];
   assign statusLed2      = ctl_q.led[2];
   assign statusLed1      = ctl_q.led[1];
   assign statusLed0      = ctl_q.led[0];

endmodule

// ---- hw/selfcheck_pkg.sv ----
// constants, state encodings and timing for the power-on self-check sequencer
package selfcheck_pkg;

   // clock and timing
   localparam int CLK_KHZ       = 20000;
   localparam int TIMEOUT_US    = 200;
   localparam int TIMEOUT_CYC   = TIMEOUT_US * CLK_KHZ / 1000;
   localparam int FLASH_HALF_MS = 250;
   localparam int FLASH_HALF_CYC_DEF = FLASH_HALF_MS * CLK_KHZ;
   localparam int SYNC_DEPTH    = 2;
   localparam int PORT_SETTLE   = 4;
   localparam int TIMER_GAP     = 4;

   // counter widths
   localparam int CNT_W   = 16;
   localparam int FLASH_W = 23;

   // self-check program region
   localparam logic [15:0] SELF_ROM_FIRST = 16'h3f00;
   localparam logic [15:0] SELF_ROM_LAST  = 16'h3fef;
   localparam logic [15:0] PC_STEP        = 16'h0001;

   // memories under test
   localparam int RAM_BYTES = 352;
   localparam int ROM_BYTES = 15936;
   localparam int RAM_AW    = 9;
   localparam int ROM_AW    = 14;
   localparam logic [ROM_AW-1:0] RAM_LAST = ROM_AW'(RAM_BYTES - 1);
   localparam logic [ROM_AW-1:0] ROM_LAST = ROM_AW'(ROM_BYTES - 1);
   localparam logic [ROM_AW-1:0] ADDR_ONE = 14'h0001;

   // test patterns
   localparam logic [7:0] PORT_PAT0   = 8'h55;
   localparam logic [7:0] PORT_PAT1   = 8'haa;
   localparam logic [7:0] SCI_PATTERN = 8'ha5;

   // led codes, bit 3 is status_led_3, a one lights the led
   localparam logic [3:0] LED_IO     = 4'h6;
   localparam logic [3:0] LED_RAM    = 4'h5;
   localparam logic [3:0] LED_TIMER  = 4'h4;
   localparam logic [3:0] LED_SCI    = 4'h3;
   localparam logic [3:0] LED_ROM    = 4'h2;
   localparam logic [3:0] LED_SPI    = 4'h1;
   localparam logic [3:0] LED_ALL_ON = 4'hf;
   localparam logic [3:0] LED_OFF    = 4'h0;

   typedef enum logic [10:0] {
      ST_IDLE  = 11'h001,
      ST_OFF   = 11'h002,
      ST_PORT  = 11'h004,
      ST_RAMW  = 11'h008,
      ST_RAMR  = 11'h010,
      ST_TIMER = 11'h020,
      ST_SCI   = 11'h040,
      ST_ROM   = 11'h080,
      ST_SPI   = 11'h100,
      ST_PASS  = 11'h200,
      ST_FAIL  = 11'h400
   } state_t;

endpackage

// ---- hw/sync_2ff.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync_2ff #(
   parameter int W = 1
) (
   input  wire logic         clk,   // core clock
   input  wire logic         rst,   // async reset, active high
   input  wire logic [W-1:0] d,     // asynchronous input
   output logic      [W-1:0] q      // synchronised output
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_t;

   sync_t s_q;
   sync_t s_d;

   always_comb
   begin
      s_d.meta   = d;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign q = s_q.stable;

endmodule

// ---- verif/power_on_self_check_sequencer_tb_top.sv ----
// self-checking bench for the self-check sequencer
`timescale 1ns/1ps
module power_on_self_check_sequencer_tb_top;
   localparam int unsigned HALF = 8;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        irqTestLevel = 1'b0;
   logic        captureInputPin = 1'b0;
   logic [2:0]  fault = 3'h0;
   logic [11:0] lag = 12'h0;
   logic [7:0]  portAIn, portBIn, portCIn, portAOut, portBOut, portCOut, sciRxData;
   logic [7:0]  ramWdata, ramRdata, romRdata, sciTxData;
   logic [8:0]  ramAddr;
   logic [13:0] romAddr;
   logic [15:0] timerCount, checkPc;
   logic        portOe, ramWe, ramRe, romRe, compareArm, sciGo, spiGo, outputCompareFlag;
   logic        receiveFullFlag, transmitEmptyFlag, transmitCompleteFlag, framingErrorFlag;
   logic        syncTransferDoneFlag, writeCollisionFlag, selfCheckActive, selfCheckDone;
   logic        statusLed3, statusLed2, statusLed1, statusLed0;
   logic [3:0]  led;
   logic [3:0]  codeTab [5] = '{4'h0, 4'h6, 4'h5, 4'h4, 4'h3};
   int          runs [$] = '{1, 2, 3, 4, 5};
   int          err_total = 0;
   int          tests_run = 0;
   logic [31:0] seed = 32'd61;
   assign led = {statusLed3, statusLed2, statusLed1, statusLed0};
   always #25 clk = ~clk;
   self_check_seq #(.FLASH_HALF_CYC(HALF)) self_check_seq_i (.*);
   test_fixture_model test_fixture_model_i (.*);
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      if (err_total == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // f picks the injected fault; 5 leaves the test level off
   task automatic run(input int f, input int hold);
      int n;
      @(posedge clk);
      seed = xs(seed);
      fault <= 3'(f);
      lag <= (f == 4) ? 12'(3000 + seed % 500) : 12'(seed % 16);
      irqTestLevel <= (f != 5);
      captureInputPin <= 1'b1;
      rst <= 1'b1;
      repeat (hold) @(posedge clk);
      rst <= 1'b0;
      n = 0;
      while (selfCheckDone !== 1'b1 && n < ((f == 5) ? 300 : 70000))
      begin
         @(negedge clk);
         n++;
      end
      chk({3'h0, selfCheckDone}, {3'h0, f != 5});
      if (f == 5)
      begin
         chk({3'h0, selfCheckActive}, 4'h0);
         chk(led, 4'h0);
      end
      else if (f > 0)
         chk(led, codeTab[f]);
      else
      begin
         chk({3'h0, selfCheckActive}, 4'h1);
         n = 0;
         while (led !== 4'hf && n < 3 * HALF)
         begin
            @(negedge clk);
            n++;
         end
         chk(led, 4'hf);
         repeat (HALF) @(negedge clk);
         chk(led, 4'h0);
      end
   endtask
   initial
   begin
      run(0, 4064);
      foreach (runs[i]) run(runs[i], 12);
      close_out();
   end
   initial
   begin
      #5000000;
      err_total++;
      close_out();
   end
endmodule
bind self_check_seq self_check_seq_assertions #(.FLASH_HALF_CYC(FLASH_HALF_CYC))
   self_check_seq_assertions_i (.*);

// ---- verif/self_check_seq_assertions.sv ----
// port assertions for the self-check sequencer
`timescale 1ns/1ps
module self_check_seq_assertions #(
   parameter int unsigned FLASH_HALF_CYC = 8
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        irqTestLevel,
   input wire logic        selfCheckActive,
   input wire logic        selfCheckDone,
   input wire logic [15:0] checkPc,
   input wire logic        portOe,
   input wire logic [7:0]  portAOut,
   input wire logic        ramWe,
   input wire logic        romRe,
   input wire logic        statusLed3,
   input wire logic        statusLed2,
   input wire logic        statusLed1,
   input wire logic        statusLed0
);
   logic [3:0] led;
   logic [3:0] ledQ;
   int         runQ;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   assign led = {statusLed3, statusLed2, statusLed1, statusLed0};
   // length of the led run that ended last cycle, times each flash half
   always_ff @(posedge clk or posedge rst)
   begin
      ledQ <= rst ? 4'h0 : led;
      runQ <= rst ? 0 : (led != ledQ) ? 1 : runQ + 1;
   end
   AST_ENTRY:
   assert property ($rose(selfCheckActive) |-> $past(irqTestLevel, 2)) else $error("bad entry");
   AST_PC_START:
   assert property ($rose(selfCheckActive) |-> checkPc == 16'h3f00) else $error("bad start");
   AST_PC_STEP:
   assert property (selfCheckActive && !selfCheckDone |=> selfCheckDone
      || checkPc == ($past(checkPc) == 16'h3fef ? 16'h3f00 : $past(checkPc) + 16'h0001))
      else $error("bad step");
   AST_PORTS:
   assert property ($rose(portOe) |-> portAOut == 8'h55 ##5 portAOut == 8'haa) else $error("pat");
   AST_RAM_ORDER:
   assert property (ramWe |-> !portOe && !romRe) else $error("ram order");
   AST_IDLE:
   assert property (!selfCheckActive |-> !portOe && !ramWe && led == 4'h0) else $error("idle");
   AST_FAIL_HOLD:
   assert property (selfCheckDone && led != 4'h0 && led != 4'hf |=> $stable(led))
      else $error("hold");
   AST_FLASH:
   assert property (selfCheckDone && !led && ledQ == 4'hf |-> runQ == FLASH_HALF_CYC)
      else $error("flash");
   COV_PORTS: cover property ($rose(portOe));
   COV_FAIL: cover property (selfCheckDone && led == 4'h4);
   COV_PASS: cover property (selfCheckDone && led == 4'hf);
endmodule

// ---- verif/test_fixture_model.sv ----
// test fixture: pin loopback, memories and peripheral responders
`timescale 1ns/1ps
module test_fixture_model (
   input  wire logic [2:0]  fault,
   input  wire logic [11:0] lag,
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  portAOut,
   input  wire logic [7:0]  portBOut,
   input  wire logic [7:0]  portCOut,
   input  wire logic        portOe,
   input  wire logic [8:0]  ramAddr,
   input  wire logic [7:0]  ramWdata,
   input  wire logic        ramWe,
   input  wire logic        ramRe,
   input  wire logic [13:0] romAddr,
   input  wire logic        romRe,
   input  wire logic        compareArm,
   input  wire logic        sciGo,
   input  wire logic [7:0]  sciTxData,
   input  wire logic        spiGo,
   output logic      [7:0]  portAIn,
   output logic      [7:0]  portBIn,
   output logic      [7:0]  portCIn,
   output logic      [7:0]  ramRdata,
   output logic      [7:0]  romRdata,
   output logic      [15:0] timerCount,
   output logic             outputCompareFlag,
   output logic      [7:0]  sciRxData,
   output logic             receiveFullFlag,
   output logic             transmitEmptyFlag,
   output logic             transmitCompleteFlag,
   output logic             framingErrorFlag,
   output logic             syncTransferDoneFlag,
   output logic             writeCollisionFlag
);
   logic [7:0]  mem [512];
   logic [7:0]  txQ;
   logic [2:0]  kind;
   logic [11:0] waitQ;
   logic        done;
   assign done = waitQ >= lag;
   // released pins read inverted; fault 1 upsets only the second pattern
   assign portAIn = portOe ? portAOut : ~portAOut;
   assign portBIn = portOe ? portBOut : ~portBOut;
   assign portCIn = (portOe ? portCOut : ~portCOut) ^ {7'h0, fault == 3'd1 && portCOut == 8'haa};
   assign outputCompareFlag = done && kind[0];
   assign {receiveFullFlag, transmitEmptyFlag, transmitCompleteFlag} =
      {3{done && kind[1]}};
   assign framingErrorFlag = 1'b0;
   assign sciRxData = receiveFullFlag ? txQ ^ {7'h0, fault == 3'd4} : ~txQ;
   assign {syncTransferDoneFlag, writeCollisionFlag} = {2{done && kind[2]}};
   always_ff @(posedge clk)
   begin
      timerCount <= rst ? 16'h0 : timerCount + {15'h0, fault != 3'd3};
      if (ramWe)
         mem[ramAddr] <= ramWdata;
      ramRdata <= ramRe ? mem[ramAddr] ^ {7'h0, fault == 3'd2 && ramAddr == 9'h15f} : ~ramRdata;
      // byte 0 reads 01 so that the xor of all bytes has odd parity
      romRdata <= romRe ? romAddr[7:0] ^ {7'h0, romAddr == 14'h0} : ~romRdata;
      if (rst || compareArm || sciGo || spiGo)
      begin
         waitQ <= 12'h0;
         kind <= rst ? 3'h0 : {spiGo, sciGo, compareArm};
         txQ <= sciTxData;
      end
      else if (!done)
         waitQ <= waitQ + 12'h1;
   end
endmodule
